// [src/dim_defines.svh]
// constants for the led dimming duty path: register offsets, fields, resets, timing
`ifndef DIM_DEFINES_SVH
`define DIM_DEFINES_SVH

`define ADDR_DUTY_HIGH_BASE  8'h00
`define ADDR_DUTY_LOW_BASE   8'h10
`define ADDR_CTRL            8'h20
`define ADDR_FREQ            8'h21
`define ADDR_ENABLE_LO       8'h22
`define ADDR_ENABLE_HI       8'h23

`define CTRL_EXP_BIT         0
`define CTRL_SHARE_BIT       1
`define CTRL_EXT_CLK_BIT     2

`define LOW_NIBBLE_RESET     4'hf
`define DUTY_FULL_HIGH       8'hff
`define CTRL_RESET           3'h0
`define ENABLE_RESET         12'h000
`define CH_LAST_GATE_A       4'h5

`define CLK_HZ               20000000
// internal divide per frequency select, entry 15 first; base = 256 x dimming freq
`define DIV_TABLE {12'h004, 12'h00d, 12'h013, 12'h018, 12'h020, 12'h027, 12'h030, 12'h041, \
                   12'h04e, 12'h061, 12'h082, 12'h09c, 12'h0c3, 12'h104, 12'h138, 12'h186}
`define MIN_DITHER_FREQ_SEL  4'ha

`define EXT_DIM_FREQ_HZ      2000
`define EXT_BASE_MULT        256
`define EXT_CLK_MAX_HZ       1000000
`define EXT_HALF_PERIOD      (`CLK_HZ / (2 * `EXT_DIM_FREQ_HZ * `EXT_BASE_MULT))

`endif

// [src/dim_pkg.sv]
// types shared by both ends of the dimming link
package dim_pkg;
    typedef logic [7:0]  reg_addr_t;
    typedef logic [7:0]  reg_data_t;
    typedef logic [11:0] duty12_t;
    typedef enum logic [1:0] {
        HOST_IDLE = 2'b01,
        HOST_FILL = 2'b10
    } host_state_t;
endpackage : dim_pkg

// [src/dim_link_if.sv]
// link between the dimming controller host and the led dimming device
`timescale 1ns/1ps
interface dim_link_if;
    logic      wr_valid;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic      shared_address_clock_pin;
    logic      dim_in_a_n;
    logic      dim_in_b_n;

    modport device (
        input wr_valid,
        input wr_addr,
        input wr_data,
        input shared_address_clock_pin,
        input dim_in_a_n,
        input dim_in_b_n
    );
    modport host (
        output wr_valid,
        output wr_addr,
        output wr_data,
        output shared_address_clock_pin,
        output dim_in_a_n,
        output dim_in_b_n
    );
endinterface : dim_link_if

// [src/led_dim_device.sv]
// twelve channel led dimming duty selection and pwm generation
//
// Behaviour
// R1: linear input is high byte over low nibble
// R2: linear on fraction (16h+l+1)/4096
// R3: low nibble all ones disables dithering
// R4: duty applied only on high byte write
// R5: share bit makes all channels use ch0
// R6: exponential table maps byte, ignores nibble
// R7: reset/fail-safe reload nv copies, nibble ones
// R8: fail-safe duty is (nv byte+1)/256
// R9: external base clock needs select and option
// R10: host supplies clock at 256x dim frequency
// R11: host keeps external clock below 1 MHz
// R12: dim inputs gate outputs 0-5 and 6-11
// R13: host sets full duty for external dimming
// R14: host keeps frequency above 2 kHz dithering
// R15: 256 base pulses per period, high byte on
// R16: frequency select picks sixteen base rates
// R17: extra pulse spread over sixteen periods
`timescale 1ns/1ps
`include "dim_defines.svh"

module led_dim_device
    import dim_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    dim_link_if.device       link,
    input  wire logic        nv_exp_curve_select,
    input  wire logic [95:0] nv_duty_byte,
    input  wire logic [3:0]  nv_dim_freq_select,
    input  wire logic        nv_internal_address_option,
    input  wire logic        fail_safe,
    output logic [11:0]      channel_current_output
);

    function automatic logic [11:0] div_of(input logic [3:0] sel);
        logic [191:0] table_bits;
        table_bits = `DIV_TABLE;
        return table_bits[int'(sel) * 12 +: 12];
    endfunction : div_of

    function automatic logic [7:0] nv_byte_of(input logic [95:0] bytes, input int ch);
        return bytes[ch * 8 +: 8];
    endfunction : nv_byte_of

    // channel address: upper nibble selects the bank, lower nibble the channel
    function automatic logic ch_hit(input reg_addr_t addr, input reg_addr_t base);
        return (addr[7:4] == base[7:4]) && (addr[3:0] < 4'hc);
    endfunction : ch_hit

    // rough exponential: 3 bit exponent, 5 bit mantissa, 0 at code 0
    function automatic duty12_t exp_lut(input logic [7:0] code);
        logic [12:0] shifted;
        shifted = 13'({1'b1, code[4:0]}) << code[7:5];
        return duty12_t'((shifted >> 1) - 13'h0010);
    endfunction : exp_lut

    // bit reversal spreads the extra pulses evenly over the group of sixteen
    function automatic logic [3:0] rev4(input logic [3:0] v);
        return {v[0], v[1], v[2], v[3]};
    endfunction : rev4

    // pin synchronisers
    logic ext_clk_meta, ext_clk_sync, ext_clk_prev;
    logic dim_a_meta, dim_a_sync, dim_b_meta, dim_b_sync;

    always_ff @(posedge clk) begin
        if (rst) begin
            ext_clk_meta <= 1'b0;
            ext_clk_sync <= 1'b0;
            ext_clk_prev <= 1'b0;
            dim_a_meta   <= 1'b1;
            dim_a_sync   <= 1'b1;
            dim_b_meta   <= 1'b1;
            dim_b_sync   <= 1'b1;
        end else begin
            ext_clk_meta <= link.shared_address_clock_pin;
            ext_clk_sync <= ext_clk_meta;
            ext_clk_prev <= ext_clk_sync;
            dim_a_meta   <= link.dim_in_a_n;
            dim_a_sync   <= dim_a_meta;
            dim_b_meta   <= link.dim_in_b_n;
            dim_b_sync   <= dim_b_meta;
        end
    end

    // configuration state
    logic            exp_curve_select, share_ch0_duty, ext_base_clock_select;
    logic [3:0]      dim_freq_select;
    logic [11:0]     channel_output_enable;
    logic [7:0]      duty_high_byte [12];
    logic [3:0]      duty_low_nibble [12];
    logic [3:0]      staged_low_nibble [12];
    logic            fail_prev;

    logic            next_exp_curve_select, next_share_ch0_duty, next_ext_base_clock_select;
    logic [3:0]      next_dim_freq_select;
    logic [11:0]     next_channel_output_enable;
    logic [7:0]      next_duty_high_byte [12];
    logic [3:0]      next_duty_low_nibble [12];
    logic [3:0]      next_staged_low_nibble [12];
    logic            next_fail_prev;

    always_comb begin
        next_exp_curve_select      = exp_curve_select;
        next_share_ch0_duty        = share_ch0_duty;
        next_ext_base_clock_select = ext_base_clock_select;
        next_dim_freq_select       = dim_freq_select;
        next_channel_output_enable = channel_output_enable;
        next_duty_high_byte        = duty_high_byte;
        next_duty_low_nibble       = duty_low_nibble;
        next_staged_low_nibble     = staged_low_nibble;
        next_fail_prev             = rst ? 1'b0 : fail_safe;
        if (rst || (fail_safe && !fail_prev)) begin
            next_exp_curve_select = nv_exp_curve_select; // R7
            next_dim_freq_select  = nv_dim_freq_select; // R7
            for (int ch = 0; ch < 12; ch++) begin
                next_duty_high_byte[ch]    = nv_byte_of(nv_duty_byte, ch); // R7
                next_duty_low_nibble[ch]   = `LOW_NIBBLE_RESET; // R7
                next_staged_low_nibble[ch] = `LOW_NIBBLE_RESET;
            end
            if (rst) begin
                next_share_ch0_duty        = 1'(`CTRL_RESET >> `CTRL_SHARE_BIT);
                next_ext_base_clock_select = 1'b0;
                next_channel_output_enable = `ENABLE_RESET;
            end
        end else if (link.wr_valid && !fail_safe) begin
            // the active low nibble only moves together with its high byte
            if (ch_hit(link.wr_addr, `ADDR_DUTY_LOW_BASE)) begin
                next_staged_low_nibble[link.wr_addr[3:0]] = link.wr_data[3:0]; // R4
            end else if (ch_hit(link.wr_addr, `ADDR_DUTY_HIGH_BASE)) begin
                next_duty_high_byte[link.wr_addr[3:0]]  = link.wr_data; // R4
                next_duty_low_nibble[link.wr_addr[3:0]] =
                    staged_low_nibble[link.wr_addr[3:0]]; // R4
            end else if (link.wr_addr == `ADDR_CTRL) begin
                next_exp_curve_select      = link.wr_data[`CTRL_EXP_BIT];
                next_share_ch0_duty        = link.wr_data[`CTRL_SHARE_BIT];
                next_ext_base_clock_select = link.wr_data[`CTRL_EXT_CLK_BIT];
            end else if (link.wr_addr == `ADDR_FREQ) begin
                next_dim_freq_select = link.wr_data[3:0];
            end else if (link.wr_addr == `ADDR_ENABLE_LO) begin
                next_channel_output_enable[7:0] = link.wr_data;
            end else if (link.wr_addr == `ADDR_ENABLE_HI) begin
                next_channel_output_enable[11:8] = link.wr_data[3:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        exp_curve_select      <= next_exp_curve_select;
        share_ch0_duty        <= next_share_ch0_duty;
        ext_base_clock_select <= next_ext_base_clock_select;
        dim_freq_select       <= next_dim_freq_select;
        channel_output_enable <= next_channel_output_enable;
        duty_high_byte        <= next_duty_high_byte;
        duty_low_nibble       <= next_duty_low_nibble;
        staged_low_nibble     <= next_staged_low_nibble;
        fail_prev             <= next_fail_prev;
    end

    // base clock and period timing
    logic [11:0] div_cnt, next_div_cnt;
    logic [7:0]  period_cnt, next_period_cnt;
    logic [3:0]  dither_frame, next_dither_frame;
    logic        int_tick, use_ext, base_tick;

    always_comb begin
        int_tick  = (div_cnt >= div_of(dim_freq_select) - 12'h001); // R16
        use_ext   = ext_base_clock_select && nv_internal_address_option; // R9
        // R10: the external pin is taken as 256 x the dimming rate
        base_tick = use_ext ? (ext_clk_sync && !ext_clk_prev) : int_tick; // R9
        next_div_cnt      = int_tick ? 12'h000 : div_cnt + 12'h001;
        next_period_cnt   = period_cnt;
        next_dither_frame = dither_frame;
        if (base_tick) begin
            next_period_cnt = period_cnt + 8'h01; // R15
            if (period_cnt == 8'hff) begin
                next_dither_frame = dither_frame + 4'h1; // R17
            end
        end
        if (rst) begin
            next_div_cnt      = 12'h000;
            next_period_cnt   = 8'h00;
            next_dither_frame = 4'h0;
        end
    end

    always_ff @(posedge clk) begin
        div_cnt      <= next_div_cnt;
        period_cnt   <= next_period_cnt;
        dither_frame <= next_dither_frame;
    end

    // per channel duty selection and output compare
    logic [11:0] next_channel_current_output;

    always_comb begin
        int      src;
        duty12_t duty;
        logic    extra;
        logic [8:0] on_count;
        logic    gate;
        src = 0;
        duty = 12'h000;
        extra = 1'b0;
        on_count = 9'h000;
        gate = 1'b1;
        for (int ch = 0; ch < 12; ch++) begin
            src = share_ch0_duty ? 0 : ch; // R5
            if (fail_safe) begin
                duty = {nv_byte_of(nv_duty_byte, ch), `LOW_NIBBLE_RESET}; // R8
            end else if (exp_curve_select) begin
                duty = exp_lut(duty_high_byte[src]); // R6
            end else begin
                duty = {duty_high_byte[src], duty_low_nibble[src]}; // R1
            end
            // nibble of all ones gives an extra pulse in every period
            extra    = (rev4(dither_frame) <= duty[3:0]); // R3 R17
            on_count = {1'b0, duty[11:4]} + {8'h00, extra}; // R2 R15
            if (!nv_internal_address_option) begin
                gate = 1'b1;
            end else if (4'(ch) <= `CH_LAST_GATE_A) begin
                gate = !dim_a_sync; // R12
            end else begin
                gate = !dim_b_sync; // R12
            end
            next_channel_current_output[ch] = channel_output_enable[ch] && gate &&
                ({1'b0, period_cnt} < on_count); // R15
        end
        if (rst) begin
            next_channel_current_output = 12'h000;
        end
    end

    always_ff @(posedge clk) begin
        channel_current_output <= next_channel_current_output;
    end

endmodule : led_dim_device

// [src/led_dim_host.sv]
// host end: forwards register writes, makes the external base clock and dim inputs
`timescale 1ns/1ps
`include "dim_defines.svh"

module led_dim_host
    import dim_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    dim_link_if.host        link,
    input  wire logic       cmd_valid,
    input  wire logic [7:0] cmd_addr,
    input  wire logic [7:0] cmd_data,
    output logic            cmd_ready,
    input  wire logic       ext_clk_run,
    input  wire logic       ext_dim_prepare,
    input  wire logic       dim_a_req,
    input  wire logic       dim_b_req
);

    localparam logic [11:0] HALF_PERIOD = 12'(`EXT_HALF_PERIOD);

    host_state_t state, next_state;
    logic [4:0]  fill_idx, next_fill_idx;
    logic        dither_used, next_dither_used;
    logic        next_cmd_ready;
    logic        next_wr_valid;
    reg_addr_t   next_wr_addr;
    reg_data_t   next_wr_data;

    always_comb begin
        next_state       = state;
        next_fill_idx    = fill_idx;
        next_dither_used = dither_used;
        next_wr_valid    = 1'b0;
        next_wr_addr     = link.wr_addr;
        next_wr_data     = link.wr_data;
        case (state)
            HOST_IDLE: begin
                if (cmd_valid) begin
                    next_wr_valid = 1'b1;
                    next_wr_addr  = cmd_addr;
                    next_wr_data  = cmd_data;
                    if (cmd_addr[7:4] == `ADDR_DUTY_LOW_BASE >> 4 &&
                        cmd_data[3:0] != `LOW_NIBBLE_RESET) begin
                        next_dither_used = 1'b1;
                    end
                    // dithering below the minimum rate would flicker
                    if (cmd_addr == `ADDR_FREQ && dither_used &&
                        cmd_data[3:0] < `MIN_DITHER_FREQ_SEL) begin
                        next_wr_data = {4'h0, `MIN_DITHER_FREQ_SEL}; // R14
                    end
                end else if (ext_dim_prepare) begin
                    next_state    = HOST_FILL;
                    next_fill_idx = 5'h00;
                end
            end
            HOST_FILL: begin
                // nibbles first, since a nibble only lands with its high byte
                next_wr_valid = 1'b1;
                if (fill_idx < 5'd12) begin
                    next_wr_addr = `ADDR_DUTY_LOW_BASE + {3'h0, fill_idx};
                    next_wr_data = {4'h0, `LOW_NIBBLE_RESET}; // R13
                end else begin
                    next_wr_addr = `ADDR_DUTY_HIGH_BASE + {3'h0, fill_idx - 5'd12};
                    next_wr_data = `DUTY_FULL_HIGH; // R13
                end
                next_fill_idx = fill_idx + 5'h01;
                if (fill_idx == 5'd23) begin
                    next_state = HOST_IDLE;
                end
            end
            default: begin
                next_state = HOST_IDLE;
            end
        endcase
        if (rst) begin
            next_state       = HOST_IDLE;
            next_fill_idx    = 5'h00;
            next_dither_used = 1'b0;
            next_wr_valid    = 1'b0;
            next_wr_addr     = 8'h00;
            next_wr_data     = 8'h00;
        end
        next_cmd_ready = (next_state == HOST_IDLE) && !rst;
    end

    always_ff @(posedge clk) begin
        state        <= next_state;
        fill_idx     <= next_fill_idx;
        dither_used  <= next_dither_used;
        cmd_ready    <= next_cmd_ready;
        link.wr_valid <= next_wr_valid;
        link.wr_addr  <= next_wr_addr;
        link.wr_data  <= next_wr_data;
    end

    // external base clock, 256 x the wanted dimming rate and under 1 MHz
    logic [11:0] half_cnt, next_half_cnt;
    logic        next_ext_clk, next_dim_a_n, next_dim_b_n;

    always_comb begin
        next_half_cnt = half_cnt;
        next_ext_clk  = link.shared_address_clock_pin;
        if (ext_clk_run) begin
            if (half_cnt >= HALF_PERIOD - 12'h001) begin
                next_half_cnt = 12'h000;
                next_ext_clk  = !link.shared_address_clock_pin; // R10 R11
            end else begin
                next_half_cnt = half_cnt + 12'h001;
            end
        end
        next_dim_a_n = !dim_a_req;
        next_dim_b_n = !dim_b_req;
        if (rst) begin
            next_half_cnt = 12'h000;
            next_ext_clk  = 1'b0;
            next_dim_a_n  = 1'b1;
            next_dim_b_n  = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        half_cnt                      <= next_half_cnt;
        link.shared_address_clock_pin <= next_ext_clk;
        link.dim_in_a_n               <= next_dim_a_n;
        link.dim_in_b_n               <= next_dim_b_n;
    end

endmodule : led_dim_host

// [testbench/led_pwm_duty_control_monitor.sv]
// assertions on the link between the dimming host and the led device
`timescale 1ns/1ps
module led_pwm_duty_control_monitor (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       wr_valid,
    input wire logic [7:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic       shared_address_clock_pin,
    input wire logic       dim_in_a_n,
    input wire logic       dim_in_b_n
);
    logic       pin_q;
    logic       next_pin_q;
    logic [7:0] gap;
    logic [7:0] next_gap;
    logic       dith;
    logic       next_dith;
    logic       edge_seen;

    assign edge_seen = shared_address_clock_pin != pin_q;

    // gap saturates so a restarted clock is not taken for a short half period
    always_comb begin
        next_pin_q = shared_address_clock_pin;
        next_gap   = edge_seen ? 8'h00 : gap + {7'h0, gap != 8'hff};
        next_dith  = dith | (wr_valid && wr_addr >= 8'h10 && wr_addr <= 8'h1b
                             && wr_data[3:0] != 4'hf);
        if (rst) begin
            next_pin_q = 1'b0;
            next_gap   = 8'hff;
            next_dith  = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        pin_q <= next_pin_q;
        gap   <= next_gap;
        dith  <= next_dith;
    end

    default clocking mon_cb @(posedge clk); endclocking
    default disable iff (rst);

    a_ext_half_exact: assert property (edge_seen && gap < 8'h28 |-> gap == 8'h12)
        else $error("external base clock half period is not 19 cycles");
    a_ext_rate_limit: assert property (edge_seen |-> gap >= 8'h09)
        else $error("external base clock faster than allowed");
    a_fill_nibbles: assert property (wr_valid && wr_addr == 8'h10 && wr_data == 8'h0f
        && !$past(wr_valid) |=> (wr_valid && wr_data == 8'h0f)[*8]
        ##1 (wr_valid && wr_data == 8'h0f)[*3] ##1 (wr_valid && wr_addr == 8'h00))
        else $error("fill nibble run is not twelve writes");
    a_fill_highs: assert property (wr_valid && wr_addr == 8'h00 && wr_data == 8'hff
        && $past(wr_valid) |=> (wr_valid && wr_data == 8'hff)[*8]
        ##1 (wr_valid && wr_data == 8'hff)[*3] ##1 !wr_valid)
        else $error("fill high byte run is not twelve writes");
    a_nibble_step: assert property (wr_valid && $past(wr_valid) && wr_data == 8'h0f
        && $past(wr_data) == 8'h0f |-> wr_addr == $past(wr_addr) + 8'h01)
        else $error("fill nibble address does not step by one");
    a_high_step: assert property (wr_valid && $past(wr_valid) && wr_data == 8'hff
        && $past(wr_data) == 8'hff |-> wr_addr == $past(wr_addr) + 8'h01)
        else $error("fill high byte address does not step by one");
    a_dither_floor: assert property (wr_valid && wr_addr == 8'h21 && dith
        |-> wr_data[3:0] >= 4'ha)
        else $error("slow frequency forwarded while dithering");
    a_write_hold: assert property (!wr_valid |-> $stable(wr_addr) && $stable(wr_data))
        else $error("write address or data moved between writes");

    c_dim_split: cover property ($rose(dim_in_b_n) && !dim_in_a_n);
endmodule : led_pwm_duty_control_monitor

// [testbench/led_pwm_duty_control_tb.sv]
// self-checking bench: host and led device joined over the dimming link
`timescale 1ns/1ps
module led_pwm_duty_control_tb;
    import dim_pkg::*;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        cmd_valid = 1'b0;
    reg_addr_t   cmd_addr = 8'h00;
    reg_data_t   cmd_data = 8'h00;
    logic        cmd_ready;
    logic        ext_clk_run = 1'b0;
    logic        ext_dim_prepare = 1'b0;
    logic        dim_a_req = 1'b1;
    logic        dim_b_req = 1'b1;
    logic        fail_safe = 1'b0;
    logic        nv_internal_address_option = 1'b1;
    logic [95:0] nv_duty_byte;
    logic [11:0] channel_current_output;
    logic [7:0]  hv [12];
    logic [15:0] cnt [12];
    logic [15:0] expv [12];
    int          errors = 0;
    int          n_compared = 0;

    dim_link_if dim_link_if_i ();

    led_dim_device led_dim_device_i (.clk(clk), .rst(rst), .link(dim_link_if_i),
        .nv_exp_curve_select(1'b0), .nv_duty_byte(nv_duty_byte),
        .nv_dim_freq_select(4'hf), .nv_internal_address_option(nv_internal_address_option),
        .fail_safe(fail_safe), .channel_current_output(channel_current_output));

    led_dim_host led_dim_host_i (.clk(clk), .rst(rst), .link(dim_link_if_i),
        .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
        .cmd_ready(cmd_ready), .ext_clk_run(ext_clk_run),
        .ext_dim_prepare(ext_dim_prepare), .dim_a_req(dim_a_req), .dim_b_req(dim_b_req));

    led_pwm_duty_control_monitor led_pwm_duty_control_monitor_i (.clk(clk), .rst(rst),
        .wr_valid(dim_link_if_i.wr_valid), .wr_addr(dim_link_if_i.wr_addr),
        .wr_data(dim_link_if_i.wr_data),
        .shared_address_clock_pin(dim_link_if_i.shared_address_clock_pin),
        .dim_in_a_n(dim_link_if_i.dim_in_a_n), .dim_in_b_n(dim_link_if_i.dim_in_b_n));

    always #25 clk = ~clk;

    // on-cycles over sixteen periods at select f (4 clk per tick)
    function automatic logic [15:0] lin_on(input logic [7:0] h, input logic [3:0] l);
        return 16'h4 * ({4'h0, h, 4'h0} + {12'h0, l} + 16'h1);
    endfunction : lin_on

    function automatic logic [15:0] exp_on(input logic [7:0] code);
        logic [15:0] v;
        v = ({10'h0, 1'b1, code[4:0]} << code[7:5]) >> 1;
        return 16'h4 * (v - 16'h10 + 16'h1);
    endfunction : exp_on

    task automatic summarize;
        if (errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] expd);
        n_compared++;
        if (seen !== expd) begin
            errors++;
            $display("[ERR] %s expected %0d seen %0d", name, expd, seen);
        end
    endtask : chk

    task automatic wr(input reg_addr_t a, input reg_data_t d);
        int k;
        k = 0;
        @(negedge clk);
        while (cmd_ready !== 1'b1 && k < 100) begin
            @(negedge clk);
            k++;
        end
        if (k >= 100) errors++;
        cmd_valid = 1'b1;
        cmd_addr  = a;
        cmd_data  = d;
        @(negedge clk);
        cmd_valid = 1'b0;
    endtask : wr

    // whole periods; under sixteen only while every nibble is all ones
    task automatic measure(input int n);
        repeat (40) @(negedge clk);
        foreach (cnt[c]) cnt[c] = 16'h0;
        repeat (n) begin
            @(negedge clk);
            foreach (cnt[c]) cnt[c] += {15'h0, channel_current_output[c] === 1'b1};
        end
    endtask : measure

    // after reset: stored bytes with nibble ones, one period per window
    task automatic t_powerup;
        wr(8'h22, 8'hff);
        wr(8'h23, 8'h0f);
        measure(1024);
        foreach (cnt[c]) expv[c] = 16'h4 * ({8'h0, nv_duty_byte[8*c +: 8]} + 16'h1);
        foreach (cnt[c]) chk($sformatf("nv_ch%0d", c), cnt[c], expv[c]);
    endtask : t_powerup

    task automatic t_linear;
        foreach (hv[c]) begin
            hv[c] = 8'h11 * 8'(c) + 8'h01;
            wr(8'h10 + 8'(c), (c == 11) ? 8'h0f : 8'(c));
            wr(8'(c), hv[c]);
            expv[c] = lin_on(hv[c], (c == 11) ? 4'hf : 4'(c));
        end
        wr(8'h21, 8'h03);
        wr(8'h21, 8'h0f);
        // staged nibble alone must leave channel 0 as it was
        wr(8'h10, 8'h07);
        measure(16384);
        foreach (cnt[c]) chk($sformatf("lin_ch%0d", c), cnt[c], expv[c]);
    endtask : t_linear

    task automatic t_share;
        wr(8'h00, hv[0]);
        wr(8'h20, 8'h02);
        measure(16384);
        foreach (cnt[c]) chk($sformatf("share_ch%0d", c), cnt[c], lin_on(hv[0], 4'h7));
    endtask : t_share

    task automatic t_exp;
        wr(8'h20, 8'h01);
        measure(16384);
        foreach (cnt[c]) chk($sformatf("exp_ch%0d", c), cnt[c], exp_on(hv[c]));
    endtask : t_exp

    task automatic t_failsafe;
        @(negedge clk);
        fail_safe = 1'b1;
        wr(8'h00, 8'h40);
        measure(16384);
        foreach (cnt[c]) expv[c] = lin_on(nv_duty_byte[8*c +: 8], 4'hf);
        foreach (cnt[c]) chk($sformatf("safe_ch%0d", c), cnt[c], expv[c]);
        @(negedge clk);
        fail_safe = 1'b0;
    endtask : t_failsafe

    // 38 clk per external tick; the write made in fail-safe must not show
    task automatic t_ext_gate;
        @(negedge clk);
        ext_clk_run = 1'b1;
        dim_b_req   = 1'b0;
        wr(8'h20, 8'h04);
        repeat (160) @(negedge clk);
        measure(9728);
        foreach (cnt[c]) expv[c] = (c < 6) ? 16'h26 * ({8'h0, nv_duty_byte[8*c +: 8]} + 16'h1)
                                           : 16'h0;
        foreach (cnt[c]) chk($sformatf("ext_ch%0d", c), cnt[c], expv[c]);
    endtask : t_ext_gate

    // option off: internal clock (13 clk at select e) and no gating
    task automatic t_no_option;
        @(negedge clk);
        nv_internal_address_option = 1'b0;
        wr(8'h21, 8'h0e);
        measure(3328);
        foreach (cnt[c]) expv[c] = 16'hd * ({8'h0, nv_duty_byte[8*c +: 8]} + 16'h1);
        foreach (cnt[c]) chk($sformatf("int_ch%0d", c), cnt[c], expv[c]);
        nv_internal_address_option = 1'b1;
    endtask : t_no_option

    task automatic t_fill;
        logic [15:0] k;
        k = 16'h0;
        @(negedge clk);
        ext_dim_prepare = 1'b1;
        @(negedge clk);
        ext_dim_prepare = 1'b0;
        chk("fill_busy", {15'h0, cmd_ready}, 16'h0);
        repeat (40) begin
            @(negedge clk);
            if (dim_link_if_i.wr_valid === 1'b1) k++;
        end
        chk("fill_writes", k, 16'h18);
    endtask : t_fill

    initial begin
        foreach (hv[c]) nv_duty_byte[8*c +: 8] = 8'h05 + 8'h13 * 8'(c);
        repeat (6) @(negedge clk);
        rst = 1'b0;
        t_powerup;
        t_linear;
        t_share;
        t_exp;
        t_failsafe;
        t_ext_gate;
        t_no_option;
        t_fill;
        summarize;
    end

    // tests need about 80000 cycles
    initial begin
        #(50 * 100000);
        errors++;
        summarize;
    end
endmodule : led_pwm_duty_control_tb
